// *** src/swdt_top.sv ***
// System watchdog timer: register slave, interval timing, interrupt write, reset pulse
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Control bit 0 write enables or disables; reads return enable in bit 0.
// - Device reset leaves the watchdog disabled and without effect.
// - Any alive write restarts the running interval.
// - Alive reads return meaningless data and restart nothing.
// - First expiry requests the bus, does one interrupt write, releases.
// - Interrupt write carries data 0x00000005 to address 0xfffbe030.
// - A second expiry after the interrupt asserts the low system reset.
// - Both intervals are one fixed count of bus clocks.
// - System reset stays asserted a fixed count of bus clocks.
// - Master error sets control bit 8; control write or reset clears it.
// - Error causes: no responder, address parity, data parity.
// - Writes take all 32 data bits, byte enables ignored.
// - Reads drive all 32 bits, unused bits zero.
// - Bursts follow protocol but only the first word acts.
// - Reset output releases on its own within the pulse time.
// - Registers decode at the standard or extended base page.
module swdt_top
#(
    parameter bit EXT_BUS          = 1'b0,
    parameter int INTERVAL_CYCLES  = swdt_pkg::SWDT_INTERVAL_CYC,
    parameter int RST_PULSE_CYCLES = swdt_pkg::SWDT_PULSE_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        bus_sel,
    input  wire logic [31:0] bus_addr,
    input  wire logic        bus_write,
    input  wire logic        bus_first,
    input  wire logic [31:0] bus_wdata,
    output logic             bus_ready,
    output logic      [31:0] bus_rdata,
    output logic             mst_req,
    input  wire logic        mst_gnt,
    output logic             mst_addr_valid,
    output logic      [31:0] mst_addr,
    output logic      [31:0] mst_wdata,
    input  wire logic        mst_ack,
    input  wire logic        mst_noresp,
    input  wire logic        mst_addr_perr,
    input  wire logic        mst_data_perr,
    output logic             system_reset_out_n,
    output logic             system_reset_oe
);
    import swdt_pkg::*;

    typedef enum logic [2:0] {W_OFF, W_RUN1, W_TOC, W_RUN2, W_RST} swdt_state_t;
    typedef enum logic [1:0] {M_IDLE, M_REQ, M_ADDR, M_WAIT} swdt_mst_t;

    localparam logic [31:0] BASE = EXT_BUS ? SWDT_BASE_EXT : SWDT_BASE_STD;

    swdt_state_t           state_ff;
    swdt_state_t           nxt_state;
    swdt_mst_t             mst_ff;
    swdt_mst_t             nxt_mst;
    logic                  enable_ff;
    logic                  nxt_enable;
    logic                  error_ff;
    logic                  nxt_error;
    logic                  ready_ff;
    logic [31:0]           rdata_ff;
    logic [31:0]           nxt_rdata;
    logic [31:0]           maddr_ff;
    logic [31:0]           nxt_maddr;
    logic [31:0]           mdata_ff;
    logic [31:0]           nxt_mdata;
    logic                  rst_drv_ff;
    logic                  hit;
    logic                  eff;
    logic                  ctrl_wr;
    logic                  alive_wr;
    logic                  ctrl_rd;
    logic                  toc_start;
    logic                  mst_done;
    logic                  mst_fail;
    logic                  cnt_restart;
    logic                  cnt_run;
    logic                  cnt_expire;
    logic [SWDT_CNT_W-1:0] cnt_limit;
    logic [SWDT_CNT_W-1:0] cnt_val;

    // Register slave decode
    assign hit      = bus_sel && (bus_addr[31:SWDT_PAGE_LSB] == BASE[31:SWDT_PAGE_LSB]);
    assign eff      = hit && bus_first;
    assign ctrl_wr  = eff && bus_write && (bus_addr[11:2] == SWDT_OFF_CTRL[11:2]);
    assign alive_wr = eff && bus_write && (bus_addr[11:2] == SWDT_OFF_ALIVE[11:2]);
    assign ctrl_rd  = eff && !bus_write && (bus_addr[11:2] == SWDT_OFF_CTRL[11:2]);

    // Error sampled only while this block owns the bus
    assign mst_done = (mst_ff == M_WAIT) && (mst_ack || mst_fail);
    assign mst_fail = mst_noresp || mst_addr_perr || mst_data_perr;

    always_comb
    begin
        // Byte enables are not even taken in: the word is always whole
        nxt_enable = ctrl_wr ? bus_wdata[SWDT_EN_BIT] : enable_ff;
        // A failing write in the same cycle as a control write still sets the flag
        if ((mst_ff == M_WAIT) && mst_fail)
            nxt_error = 1'b1;
        else if (ctrl_wr)
            nxt_error = 1'b0;
        else
            nxt_error = error_ff;
        nxt_rdata = '0;
        if (ctrl_rd)
        begin
            nxt_rdata[SWDT_EN_BIT]  = enable_ff;
            nxt_rdata[SWDT_ERR_BIT] = error_ff;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            enable_ff <= SWDT_EN_RST;
            error_ff  <= SWDT_ERR_RST;
            ready_ff  <= 1'b0;
            rdata_ff  <= '0;
        end
        else if (clk_en)
        begin
            enable_ff <= nxt_enable;
            error_ff  <= nxt_error;
            ready_ff  <= hit;
            rdata_ff  <= nxt_rdata;
        end
    end

    assign bus_ready = ready_ff;
    assign bus_rdata = rdata_ff;

    // Watchdog sequence
    always_comb
    begin
        nxt_state   = state_ff;
        cnt_restart = 1'b0;
        toc_start   = 1'b0;
        unique case (state_ff)
            W_OFF:
                if (enable_ff)
                    nxt_state = W_RUN1;
            W_RUN1:
                if (!enable_ff)
                    nxt_state = W_OFF;
                else if (alive_wr)
                    cnt_restart = 1'b1;
                else if (cnt_expire)
                begin
                    nxt_state = W_TOC;
                    toc_start = 1'b1;
                end
            // Alive writes here do not cancel a write already under way
            W_TOC:
                if (mst_done)
                    nxt_state = enable_ff ? W_RUN2 : W_OFF;
            W_RUN2:
                if (!enable_ff)
                    nxt_state = W_OFF;
                else if (alive_wr)
                    nxt_state = W_RUN1;
                else if (cnt_expire)
                    nxt_state = W_RST;
            // The pulse always runs out, even if software disables meanwhile
            W_RST:
                if (cnt_expire)
                    nxt_state = W_OFF;
        endcase
        if ((nxt_state != state_ff) && (nxt_state inside {W_RUN1, W_RUN2, W_RST}))
            cnt_restart = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_ff   <= W_OFF;
            rst_drv_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            state_ff   <= nxt_state;
            rst_drv_ff <= (nxt_state == W_RST);
        end
    end

    assign cnt_run   = state_ff inside {W_RUN1, W_RUN2, W_RST};
    assign cnt_limit = (state_ff == W_RST) ? SWDT_CNT_W'(RST_PULSE_CYCLES)
                                           : SWDT_CNT_W'(INTERVAL_CYCLES);

    swdt_interval_cnt u_cnt
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .restart (cnt_restart),
        .run     (cnt_run),
        .limit   (cnt_limit),
        .count   (cnt_val),
        .expire  (cnt_expire)
    );

    // Open-drain reset pin: only ever pulls low
    assign system_reset_oe    = rst_drv_ff;
    assign system_reset_out_n = !rst_drv_ff;

    // Bus master for the single interrupt write
    always_comb
    begin
        nxt_mst   = mst_ff;
        nxt_maddr = maddr_ff;
        nxt_mdata = mdata_ff;
        unique case (mst_ff)
            M_IDLE:
                if (toc_start)
                    nxt_mst = M_REQ;
            M_REQ:
                if (mst_gnt)
                begin
                    nxt_mst   = M_ADDR;
                    nxt_maddr = SWDT_TOC_ADDR;
                    nxt_mdata = SWDT_TOC_DATA;
                end
            M_ADDR:
                nxt_mst = M_WAIT;
            M_WAIT:
                if (mst_done)
                begin
                    nxt_mst   = M_IDLE;
                    nxt_maddr = '0;
                    nxt_mdata = '0;
                end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mst_ff   <= M_IDLE;
            maddr_ff <= '0;
            mdata_ff <= '0;
        end
        else if (clk_en)
        begin
            mst_ff   <= nxt_mst;
            maddr_ff <= nxt_maddr;
            mdata_ff <= nxt_mdata;
        end
    end

    assign mst_req        = (mst_ff != M_IDLE);
    assign mst_addr_valid = (mst_ff == M_ADDR);
    assign mst_addr       = maddr_ff;
    assign mst_wdata      = mdata_ff;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    enable_write_a: assert property (
        clk_en && ctrl_wr |=> enable_ff == $past(bus_wdata[SWDT_EN_BIT]) && !$past(bus_rdata[1]))
        else $error("enable bit did not follow control write");
    off_quiet_a: assert property (
        state_ff == W_OFF && mst_ff == M_IDLE |-> !mst_req && system_reset_out_n && !system_reset_oe)
        else $error("disabled watchdog disturbs the system");
    alive_restart_a: assert property (
        clk_en && alive_wr && state_ff inside {W_RUN1, W_RUN2} && enable_ff |=> cnt_val == '0 && state_ff == W_RUN1)
        else $error("alive write did not restart the interval");
    alive_read_a: assert property (
        clk_en && eff && !bus_write && bus_addr[11:2] == SWDT_OFF_ALIVE[11:2] && state_ff == W_RUN1 && enable_ff
        && !cnt_expire |=> cnt_val == $past(cnt_val) + 1'b1 && bus_rdata == '0)
        else $error("alive read disturbed the interval");
    toc_write_a: assert property (
        mst_ff == M_REQ && mst_gnt && clk_en
        |=> mst_addr_valid && mst_addr == SWDT_TOC_ADDR && mst_wdata == SWDT_TOC_DATA)
        else $error("interrupt write address or data wrong");
    first_interval_a: assert property (
        clk_en && state_ff == W_RUN1 && nxt_state == W_TOC |-> cnt_val == SWDT_CNT_W'(INTERVAL_CYCLES - 1))
        else $error("first interval length wrong");
    reset_assert_a: assert property (
        clk_en && state_ff == W_RUN2 && cnt_expire && !alive_wr && enable_ff |=> !system_reset_out_n)
        else $error("second expiry did not assert reset");
    pulse_len_a: assert property (
        $rose(system_reset_out_n) |-> $past(cnt_val) == SWDT_CNT_W'(RST_PULSE_CYCLES - 1))
        else $error("reset pulse length wrong");
    error_set_a: assert property (
        clk_en && mst_ff == M_WAIT && mst_fail |=> error_ff && mst_ff == M_IDLE)
        else $error("master error not flagged");
    error_clear_a: assert property (
        clk_en && ctrl_wr && !(mst_ff == M_WAIT && mst_fail) |=> !error_ff)
        else $error("control write did not clear error");
    ready_a: assert property (
        clk_en && hit |=> bus_ready && bus_rdata[31:9] == '0 && bus_rdata[7:1] == '0)
        else $error("bus access not answered cleanly");
    burst_tail_a: assert property (
        clk_en && hit && !bus_first |=> enable_ff == $past(enable_ff) && bus_rdata == '0)
        else $error("later burst word took effect");

    toc_c: cover property (mst_addr_valid ##[1:20] mst_done);
    reset_c: cover property ($fell(system_reset_out_n));
    error_c: cover property ($rose(error_ff));
    rescue_c: cover property (state_ff == W_RUN2 && alive_wr && clk_en);
endmodule
`default_nettype wire

// *** shared/swdt_pkg.sv ***
// Constants shared by the system watchdog timer files
package swdt_pkg;
    // Register page bases on the standard and extended bus
    localparam logic [31:0] SWDT_BASE_STD    = 32'hf020_3000;
    localparam logic [31:0] SWDT_BASE_EXT    = 32'hffe0_3000;
    localparam int          SWDT_PAGE_LSB    = 12;
    // Register offsets inside the page
    localparam logic [11:0] SWDT_OFF_CTRL    = 12'h000;
    localparam logic [11:0] SWDT_OFF_ALIVE   = 12'h004;
    // Control register fields and reset values
    localparam int          SWDT_EN_BIT      = 0;
    localparam int          SWDT_ERR_BIT     = 8;
    localparam logic        SWDT_EN_RST      = 1'b0;
    localparam logic        SWDT_ERR_RST     = 1'b0;
    // Hard-wired timeout interrupt write
    localparam logic [31:0] SWDT_TOC_ADDR    = 32'hfffb_e030;
    localparam logic [31:0] SWDT_TOC_DATA    = 32'h0000_0005;
    // Intervals are fixed clock counts, quoted at a 30 MHz reference clock
    localparam longint      SWDT_REF_CLK_KHZ = 30000;
    localparam longint      SWDT_INTERVAL_US = 350000;
    localparam longint      SWDT_PULSE_US    = 2200;
    localparam int          SWDT_INTERVAL_CYC = int'(SWDT_INTERVAL_US * SWDT_REF_CLK_KHZ / 64'd1000);
    localparam int          SWDT_PULSE_CYC    = int'(SWDT_PULSE_US * SWDT_REF_CLK_KHZ / 64'd1000);
    localparam int          SWDT_CNT_W       = 24;
endpackage

// *** src/swdt_interval_cnt.sv ***
// Interval counter of the system watchdog timer
`timescale 1ns/1ps
`default_nettype none
module swdt_interval_cnt
(
    input  wire logic                            ref_clk,
    input  wire logic                            sys_rst,
    input  wire logic                            clk_en,
    input  wire logic                            restart,
    input  wire logic                            run,
    input  wire logic [swdt_pkg::SWDT_CNT_W-1:0] limit,
    output logic      [swdt_pkg::SWDT_CNT_W-1:0] count,
    output logic                                 expire
);
    import swdt_pkg::*;

    logic [SWDT_CNT_W-1:0] cnt_ff;
    logic [SWDT_CNT_W-1:0] nxt_cnt;

    // Holds at the last value once expired, until restarted
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (restart)
            nxt_cnt = '0;
        else if (run && !expire)
            nxt_cnt = cnt_ff + 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            cnt_ff <= '0;
        else if (clk_en)
            cnt_ff <= nxt_cnt;
    end

    assign count  = cnt_ff;
    assign expire = run && (cnt_ff == limit - 1'b1);
endmodule
`default_nettype wire

// *** verification/swdt_bus_model.sv ***
// Arbiter and interrupt target model facing the watchdog bus master
`timescale 1ns/1ps
`default_nettype none
module swdt_bus_model
(
    input  wire logic        ref_clk,
    input  wire logic        mst_req,
    input  wire logic        mst_addr_valid,
    input  wire logic [31:0] mst_addr,
    input  wire logic [31:0] mst_wdata,
    input  wire logic [1:0]  fail_mode,
    output logic             mst_gnt,
    output logic             mst_ack,
    output logic             mst_noresp,
    output logic             mst_addr_perr,
    output logic             mst_data_perr,
    output logic      [31:0] seen_addr,
    output logic      [31:0] seen_data,
    output var int           seen_cnt
);
    int   wait_cnt;
    logic in_wait;
    initial
    begin
        {mst_gnt, mst_ack, mst_noresp, mst_addr_perr, mst_data_perr, in_wait} = 6'h00;
        {seen_addr, seen_data} = 64'h0;
        seen_cnt = 0;
        wait_cnt = 0;
    end
    // Grant is slow on purpose; the answer is held until the request drops
    always @(negedge ref_clk)
    begin
        wait_cnt <= mst_req ? wait_cnt + 1 : 0;
        mst_gnt  <= mst_req && wait_cnt >= 2;
        if (mst_addr_valid)
        begin
            seen_addr <= mst_addr;
            seen_data <= mst_wdata;
            seen_cnt  <= seen_cnt + 1;
            in_wait   <= 1'b1;
        end
        else if (!mst_req)
            in_wait <= 1'b0;
        // Mode 0 acknowledges, modes 1 to 3 pick one failure cause
        {mst_data_perr, mst_addr_perr, mst_noresp, mst_ack} <= (in_wait && mst_req) ? 4'h1 << fail_mode : 4'h0;
    end
endmodule
`default_nettype wire

// *** verification/swdt_top_tb.sv ***
// Self-checking bench for the system watchdog timer
`timescale 1ns/1ps
`default_nettype none
module swdt_top_tb;
    import swdt_pkg::*;
    localparam int          N = 40;
    localparam int          P = 10;
    localparam logic [31:0] B = SWDT_BASE_STD;
    localparam logic [31:0] A = SWDT_BASE_STD + 32'h4;
    logic        ref_clk, sys_rst, clk_en, bus_sel, bus_write, bus_first, bus_ready, mst_req, mst_gnt;
    logic        mst_addr_valid, mst_ack, mst_noresp, mst_addr_perr, mst_data_perr;
    logic        system_reset_out_n, system_reset_oe;
    logic [31:0] bus_addr, bus_wdata, bus_rdata, mst_addr, mst_wdata, seen_addr, seen_data, r;
    logic [1:0]  fail_mode;
    int          failures, check_count, seen_cnt, hits, n;
    swdt_top #(.INTERVAL_CYCLES(N), .RST_PULSE_CYCLES(P)) i_swdt_top
    (
        .ref_clk, .sys_rst, .clk_en, .bus_sel, .bus_addr, .bus_write, .bus_first, .bus_wdata, .bus_ready,
        .bus_rdata, .mst_req, .mst_gnt, .mst_addr_valid, .mst_addr, .mst_wdata, .mst_ack, .mst_noresp,
        .mst_addr_perr, .mst_data_perr, .system_reset_out_n, .system_reset_oe
    );
    swdt_bus_model i_swdt_bus_model
    (
        .ref_clk, .mst_req, .mst_addr_valid, .mst_addr, .mst_wdata, .fail_mode, .mst_gnt, .mst_ack,
        .mst_noresp, .mst_addr_perr, .mst_data_perr, .seen_addr, .seen_data, .seen_cnt
    );
    initial
    begin
        {ref_clk, sys_rst, clk_en, bus_sel, bus_write, bus_first} = 6'h18;
        {bus_addr, bus_wdata, fail_mode} = 66'h0;
        {failures, check_count, hits} = 96'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Counts cycles in which the block requests the bus or drives the reset pin low
    task automatic tick(input int k);
        repeat (k)
        begin
            @(negedge ref_clk);
            if (mst_req !== 1'b0 || system_reset_out_n !== 1'b1)
                hits++;
        end
    endtask
    // Select stays up so that callers can chain words back to back
    task automatic acc(input logic [31:0] a, input logic w, input logic f, input logic [31:0] d);
        {bus_sel, bus_addr, bus_write, bus_first, bus_wdata} = {1'b1, a, w, f, d};
        @(negedge ref_clk);
        r = (bus_ready === 1'b1) ? bus_rdata : 32'hffff_ffff;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        acc(a, 1'b1, 1'b1, d);
        bus_sel = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        acc(a, 1'b0, 1'b1, 32'h0);
        bus_sel = 1'b0;
        chk(what, exp, r);
        @(negedge ref_clk);
    endtask
    task automatic wt(input bit pin, input logic lvl, input int lim);
        n = 0;
        while ((pin ? system_reset_out_n : mst_req) !== lvl && n < lim)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= lim)
        begin
            failures++;
            $display("FAIL wait expected %b seen timeout", lvl);
            wrap_up();
        end
    endtask
    task automatic t_reset;
        chk("reset oe", 32'h0, 32'(system_reset_oe));
        rd(B, 32'h0, "ctrl after reset");
        rd(A, 32'h0, "alive read");
        rd(B + 32'h8, 32'h0, "undefined read");
        rd(32'hf020_4000, 32'hffff_ffff, "foreign page");
        tick(N + 10);
        chk("disabled quiet", 32'h0, 32'(hits));
        $display("t_reset done");
    endtask
    task automatic t_regs;
        wr(B, 32'hffff_fe01);
        rd(B, 32'h1, "ctrl enable");
        wr(B, 32'h0);
        rd(B, 32'h0, "ctrl disable");
        wr(B + 32'h8, 32'h1);
        rd(B, 32'h0, "undefined write");
        acc(B, 1'b1, 1'b1, 32'h1);
        acc(B, 1'b1, 1'b0, 32'h0);
        acc(B, 1'b0, 1'b0, 32'h0);
        bus_sel = 1'b0;
        chk("tail word read", 32'h0, r);
        tick(1);
        rd(B, 32'h1, "tail write ignored");
        wr(B, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_toc;
        wr(B, 32'h1);
        wt(0, 1'b1, N + 20);
        chk("first interval", 32'h1, 32'(n >= N - 2 && n <= N + 2));
        wt(0, 1'b0, 20);
        chk("write count", 32'h1, 32'(seen_cnt));
        chk("write addr", 32'hfffb_e030, seen_addr);
        chk("write data", 32'h0000_0005, seen_data);
        wt(1, 1'b0, N + 20);
        chk("second interval", 32'h1, 32'(n >= N - 2 && n <= N + 2));
        chk("reset drive", 32'h1, 32'(system_reset_oe));
        wt(1, 1'b1, P + 5);
        chk("pulse length", 32'(P), 32'(n));
        rd(B, 32'h1, "no error on ack");
        wr(B, 32'h0);
        chk("one write", 32'h1, 32'(seen_cnt));
        $display("t_toc done");
    endtask
    task automatic t_alive;
        wr(B, 32'h1);
        hits = 0;
        repeat (3)
        begin
            tick(N - 10);
            wr(A, 32'h1234_5678);
        end
        chk("alive keeps quiet", 32'h0, 32'(hits));
        repeat (3)
        begin
            tick(8);
            rd(A, 32'h0, "alive read");
        end
        wt(0, 1'b1, N);
        chk("reads restart nothing", 32'h1, 32'(n + 30 >= N - 3 && n + 30 <= N + 2));
        wt(0, 1'b0, 20);
        wr(A, 32'h0);
        wt(0, 1'b1, N + 20);
        chk("alive after interrupt", 32'h1, 32'(n >= N - 2 && n <= N + 2));
        wt(0, 1'b0, 20);
        wr(B, 32'h0);
        chk("no reset pulse", 32'h1, 32'(system_reset_out_n));
        $display("t_alive done");
    endtask
    task automatic t_err;
        for (int m = 1; m < 4; m++)
        begin
            fail_mode = 2'(m);
            wr(B, 32'h1);
            wt(0, 1'b1, N + 20);
            wt(0, 1'b0, 20);
            rd(B, 32'h0000_0101, "error set");
            wr(B, 32'h1);
            rd(B, 32'h1, "error cleared");
            wr(B, 32'h0);
        end
        // A mid-run reset must drop a pending error together with the enable
        fail_mode = 2'h1;
        wr(B, 32'h1);
        wt(0, 1'b1, N + 20);
        wt(0, 1'b0, 20);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        rd(B, 32'h0, "reset clears error");
        fail_mode = 2'h0;
        $display("t_err done");
    endtask
    // Frozen cycles must neither count nor take bus words
    task automatic t_hold;
        wr(B, 32'h1);
        clk_en = 1'b0;
        tick(20);
        acc(B, 1'b0, 1'b1, 32'h0);
        bus_sel = 1'b0;
        clk_en  = 1'b1;
        chk("frozen access", 32'hffff_ffff, r);
        wt(0, 1'b1, N + 40);
        chk("frozen interval", 32'h1, 32'(n >= N - 2 && n <= N + 2));
        wt(0, 1'b0, 20);
        wr(B, 32'h0);
        $display("t_hold done");
    endtask
    initial
    begin
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset();
        t_regs();
        t_toc();
        t_alive();
        t_err();
        t_hold();
        wrap_up();
    end
endmodule
`default_nettype wire
